//--- srm_pkg.sv
// constants and carrier types for the self refresh / mode register read block
// assumes a single command clock shared with the controller at 25 MHz
package srm_pkg;

  // ----------------------------------------
  // mode register map
  // ----------------------------------------
  localparam logic [7:0] MR_ADDR_TEMP = 8'h04;
  localparam logic [7:0] MR_ADDR_BANK_MASK = 8'h10;
  localparam logic [7:0] MR_ADDR_SEG_MASK = 8'h11;
  localparam logic [7:0] BANK_MASK_RESET = 8'h00;
  localparam logic [7:0] SEG_MASK_RESET = 8'h00;
  localparam logic [2:0] TEMP_RESET = 3'h3;
  localparam int TEMP_LSB = 0;

  // ----------------------------------------
  // array organisation
  // ----------------------------------------
  localparam logic [2:0] BANK_LAST = 3'h7;        // 3'h3 for four-bank densities
  localparam logic SEG_MASK_SUPPORTED = 1'b1;      // clear below 1Gb

  // ----------------------------------------
  // command encodings on the rising-edge half
  // ----------------------------------------
  localparam logic [3:0] CA_OP_MRR = 4'h8;         // ca3..ca0 = 1000
  localparam logic [3:0] CA_OP_MRW = 4'h0;         // ca3..ca0 = 0000
  localparam logic [2:0] CA_OP_SRE = 3'h4;         // ca2..ca0 = 100

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_XSR_NS = 140;
  localparam int T_XSR_CYC = (T_XSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CKESR_NS = 15;
  localparam int T_CKESR_CYC = (T_CKESR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_SR_REF_NS = 3900;
  localparam int T_SR_REF_CYC = T_SR_REF_NS / CLK_PERIOD_NS;
  localparam int T_TSI_MS = 32;
  localparam int T_TSI_CYC = T_TSI_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0] READ_LATENCY = 4'h3;
  localparam logic [3:0] MRR_BURST_BEATS = 4'h4;
  localparam logic [3:0] MRR_END = READ_LATENCY + MRR_BURST_BEATS;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic cs_n;
    logic [9:0] ca_r;
    logic [9:0] ca_f;
  } srm_cmd_t;

  typedef struct packed {
    logic [31:0] dq;
    logic [3:0] dqs;
    logic dq_oe_n;
  } srm_dq_t;

  typedef enum logic [1:0] {srm_active, srm_self_ref, srm_exit} srm_state_t;

endpackage

//--- srm_mode_reg_store.sv
// mode register store: masks, temperature status, registered read port
// assumes writes and reads never collide on the same cycle
`timescale 1ns/1ns
`default_nettype none
module srm_mode_reg_store
  import srm_pkg::*;
(
  input wire logic clk,             // command clock
  input wire logic rst_n,           // async reset, active low
  input wire logic wr_en,           // mode register write
  input wire logic [7:0] wr_addr,   // write address
  input wire logic [7:0] wr_data,   // write data
  input wire logic temp_we,         // sensor status update
  input wire logic [2:0] temp_code, // synchronised sensor code
  input wire logic rd_en,           // mode register read
  input wire logic [7:0] rd_addr,   // read address
  output logic [7:0] rd_data,       // registered read data
  output logic [7:0] bank_mask,     // bank mask contents
  output logic [7:0] seg_mask       // segment mask contents
);

  logic [2:0] temp_status;

  // ----------------------------------------
  // writable masks
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_mask <= BANK_MASK_RESET;
      seg_mask <= SEG_MASK_RESET;
    end else if (wr_en) begin
      if (wr_addr == MR_ADDR_BANK_MASK) begin
        bank_mask <= wr_data;
      end else if (wr_addr == MR_ADDR_SEG_MASK) begin
        seg_mask <= wr_data;
      end
    end
  end

  // temperature status is read-only; writes to it are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_status <= TEMP_RESET;
    end else if (temp_we) begin
      temp_status <= temp_code;
    end
  end

  // ----------------------------------------
  // read port, unmapped addresses read zero
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      if (rd_addr == MR_ADDR_BANK_MASK) begin
        rd_data <= bank_mask;
      end else if (rd_addr == MR_ADDR_SEG_MASK) begin
        rd_data <= seg_mask;
      end else if (rd_addr == MR_ADDR_TEMP) begin
        rd_data <= {5'h00, temp_status};
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

endmodule // srm_mode_reg_store
`default_nettype wire

//--- srm_self_refresh.sv
// device-side self refresh exit, partial-array masking and mode register read
// assumes the controller drives cke and the command bus on this same clock
//
// Rules for this block and for its controller
// [R1] controller starts stable clock before raising cke
// [R2] controller gives two stable clocks before exit
// [R3] no valid command until exit interval ends
// [R4] cke high and nops throughout exit interval
// [R5] exit interval counts from first edge, cke high
// [R6] controller refreshes once before next self refresh
// [R7] all banks idle before self refresh entry
// [R8] eight-bit bank mask register, one bit per bank
// [R9] bank mask at 10h, segment mask at 11h
// [R10] masked bank gets no self refresh
// [R11] unmasked bank refreshed per segment mask bits
// [R12] eight segments at 1Gb and above only
// [R13] masked segment skipped, unmasked segment refreshed
// [R14] segment bit applies to every bank alike
// [R15] mode register read decode and address fields
// [R16] register value on dq low byte, first beat
// [R17] all strobes toggle during read burst
// [R18] four-beat uninterrupted read, two-clock command period
// [R19] controller spaces mode write and write after read
// [R20] read to mode read spacing is bl/2
// [R21] write to mode read spacing rule
// [R22] mode read never cuts a burst short
// [R23] temperature status readable, fresh within update interval
// [R24] self refresh entry decode, cke high before
// [R25] stay at least ckesr, one internal refresh
// [R26] refresh only where bank and segment unmasked
`timescale 1ns/1ns
`default_nettype none
module srm_self_refresh
  import srm_pkg::*;
#(
  parameter int TSI_CYCLES = T_TSI_CYC     // sensor update interval in clocks
)(
  input wire logic clk,                   // command clock
  input wire logic rst_n,                 // async reset, active low
  input wire logic cke,                   // clock enable from controller
  input wire srm_cmd_t cmd,               // chip select and command/address
  input wire logic [2:0] temp_sensor,     // raw sensor code, asynchronous
  output srm_dq_t dq_bus,                 // data, strobes, output enable
  output logic sr_active,                 // in self refresh
  output logic xsr_busy,                  // exit interval running
  output logic ref_strobe,                // one internal segment refresh
  output logic ref_all,                   // internal all-bank refresh
  output logic [2:0] ref_bank,            // bank of ref_strobe
  output logic [2:0] ref_segment          // segment of ref_strobe
);

  srm_state_t state;
  logic [7:0] phase_cnt, rd_data, bank_mask, seg_mask, seg_eff, mr_addr;
  logic [3:0] mrr_cnt;
  logic [11:0] ref_cnt;
  logic [5:0] ref_ptr;
  logic [19:0] tsi_cnt;
  logic [2:0] temp_s1, temp_s2;
  logic cke_q, can_cmd, is_mrr, is_mrw, is_sre, accept_mrr, accept_mrw, accept_sre;
  logic exit_start, tsi_tick, ref_tick;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // every command also waits out any read burst, so nothing can cut one short
  assign can_cmd = (state == srm_active) && (mrr_cnt == 4'h0);                 // R3 R18 R22
  assign is_mrr = cke && cke_q && !cmd.cs_n && (cmd.ca_r[3:0] == CA_OP_MRR);  // R15
  assign is_mrw = cke && cke_q && !cmd.cs_n && (cmd.ca_r[3:0] == CA_OP_MRW);
  assign is_sre = !cke && cke_q && !cmd.cs_n && (cmd.ca_r[2:0] == CA_OP_SRE); // R24
  assign mr_addr = {cmd.ca_r[9:4], cmd.ca_f[1:0]};                             // R15
  assign accept_mrr = is_mrr && can_cmd;
  assign accept_mrw = is_mrw && can_cmd;
  assign accept_sre = is_sre && can_cmd;
  assign exit_start = (state == srm_self_ref) && (phase_cnt == 8'h00) && cke;  // R25

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke;
    end
  end

  // ----------------------------------------
  // self refresh state machine
  // ----------------------------------------
  // cke sampled high is the first edge of the exit interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= srm_active;
      phase_cnt <= 8'h00;
      sr_active <= 1'b0;
      xsr_busy <= 1'b0;
    end else begin
      case (state)
        srm_active: begin
          if (accept_sre) begin
            state <= srm_self_ref;
            phase_cnt <= 8'(T_CKESR_CYC - 1);                                 // R25
            sr_active <= 1'b1;
          end
        end
        srm_self_ref: begin
          if (exit_start) begin
            state <= srm_exit;
            phase_cnt <= 8'(T_XSR_CYC - 1);                                   // R5
            sr_active <= 1'b0;
            xsr_busy <= 1'b1;
          end else if (phase_cnt != 8'h00) begin
            phase_cnt <= phase_cnt - 8'h01;
          end
        end
        srm_exit: begin
          // commands seen here are ignored; the controller sends nops only
          if (phase_cnt <= 8'h01) begin                                       // R3 R4
            state <= srm_active;
            phase_cnt <= 8'h00;
            xsr_busy <= 1'b0;
          end else begin
            phase_cnt <= phase_cnt - 8'h01;
          end
        end
        default: begin
          state <= srm_active;
        end
      endcase
    end
  end

  // ----------------------------------------
  // partial-array refresh masking
  // ----------------------------------------
  // below 1Gb the segment bits are forced unmasked
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_seg
      assign seg_eff[g] = seg_mask[g] && SEG_MASK_SUPPORTED;                  // R12
    end
  endgenerate

  assign ref_tick = (state == srm_self_ref) && (ref_cnt == 12'(T_SR_REF_CYC - 1));

  // internal timer walks bank by segment; masked cells get no strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt <= 12'h000;
      ref_ptr <= 6'h00;
      ref_strobe <= 1'b0;
      ref_all <= 1'b0;
      ref_bank <= 3'h0;
      ref_segment <= 3'h0;
    end else begin
      ref_all <= accept_sre;                                                  // R25
      ref_strobe <= 1'b0;
      if (state != srm_self_ref) begin
        ref_cnt <= 12'h000;
      end else if (ref_tick) begin
        ref_cnt <= 12'h000;
        ref_bank <= ref_ptr[5:3];
        ref_segment <= ref_ptr[2:0];
        ref_strobe <= !bank_mask[ref_ptr[5:3]] && !seg_eff[ref_ptr[2:0]];     // R10 R11 R13 R14 R26
        if (ref_ptr == {BANK_LAST, 3'h7}) begin
          ref_ptr <= 6'h00;
        end else begin
          ref_ptr <= ref_ptr + 6'h01;
        end
      end else begin
        ref_cnt <= ref_cnt + 12'h001;
      end
    end
  end

  // ----------------------------------------
  // temperature sensor capture
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_s1 <= 3'h0;
      temp_s2 <= 3'h0;
    end else begin
      temp_s1 <= temp_sensor;
      temp_s2 <= temp_s1;
    end
  end

  // status also refreshed at exit so it is never stale after self refresh
  assign tsi_tick = (tsi_cnt == 20'(TSI_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tsi_cnt <= 20'h00000;
    end else if (tsi_tick || exit_start) begin                                 // R23
      tsi_cnt <= 20'h00000;
    end else begin
      tsi_cnt <= tsi_cnt + 20'h00001;
    end
  end

  srm_mode_reg_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(accept_mrw),                                                       // R8 R9
    .wr_addr(mr_addr),
    .wr_data(cmd.ca_f[9:2]),
    .temp_we(tsi_tick || exit_start),                                         // R23
    .temp_code(temp_s2),
    .rd_en(accept_mrr),
    .rd_addr(mr_addr),
    .rd_data(rd_data),
    .bank_mask(bank_mask),
    .seg_mask(seg_mask)
  );

  // ----------------------------------------
  // mode register read burst
  // ----------------------------------------
  // one beat per clock; store data is ready long before the first beat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mrr_cnt <= 4'h0;
    end else if (accept_mrr) begin
      mrr_cnt <= 4'h1;
    end else if (mrr_cnt == MRR_END) begin
      mrr_cnt <= 4'h0;
    end else if (mrr_cnt != 4'h0) begin
      mrr_cnt <= mrr_cnt + 4'h1;                                              // R18
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_bus <= '{dq: 32'h00000000, dqs: 4'h0, dq_oe_n: 1'b1};
    end else if (mrr_cnt >= READ_LATENCY && mrr_cnt < MRR_END) begin
      dq_bus.dq_oe_n <= 1'b0;
      dq_bus.dqs <= (mrr_cnt == READ_LATENCY) ? 4'hF : ~dq_bus.dqs;           // R17
      dq_bus.dq <= (mrr_cnt == READ_LATENCY) ? {24'h000000, rd_data} : 32'h00000000; // R16
    end else begin
      dq_bus <= '{dq: 32'h00000000, dqs: 4'h0, dq_oe_n: 1'b1};
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  localparam int A_RL = 4;

  default clocking a_clk @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_first_beat;
    accept_mrr && mr_addr == MR_ADDR_BANK_MASK |-> ##A_RL dq_bus.dq[7:0] == $past(bank_mask, A_RL);
  endproperty
  a_first_beat: assert property (p_first_beat) else $error("mrr first beat wrong"); // R16
  property p_burst_len;
    $fell(dq_bus.dq_oe_n) |-> !dq_bus.dq_oe_n [*4] ##1 dq_bus.dq_oe_n;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("mrr burst not four beats"); // R18
  property p_dqs_toggle;
    !dq_bus.dq_oe_n && !$past(dq_bus.dq_oe_n) |-> dq_bus.dqs == ~$past(dq_bus.dqs);
  endproperty
  a_dqs_toggle: assert property (p_dqs_toggle) else $error("dqs did not toggle"); // R17
  property p_no_cut;
    accept_mrr |=> (!accept_mrr && !accept_mrw && !accept_sre) [*7];
  endproperty
  a_no_cut: assert property (p_no_cut) else $error("command taken inside mrr"); // R22
  property p_sre_entry;
    is_sre && state == srm_active && mrr_cnt == 4'h0 |=> sr_active && ref_all;
  endproperty
  a_sre_entry: assert property (p_sre_entry) else $error("self refresh not entered"); // R24
  property p_stay;
    sr_active && !cke |=> sr_active;
  endproperty
  a_stay: assert property (p_stay) else $error("left self refresh with cke low"); // R25
  property p_xsr_len;
    $rose(xsr_busy) |-> xsr_busy [*3] ##1 (!xsr_busy && state == srm_active);
  endproperty
  a_xsr_len: assert property (p_xsr_len) else $error("exit interval length wrong"); // R5
  property p_masked;
    ref_strobe |-> !bank_mask[ref_bank] && !seg_eff[ref_segment];
  endproperty
  a_masked: assert property (p_masked) else $error("masked cell refreshed"); // R26
  property p_mrw_bank;
    accept_mrw && mr_addr == MR_ADDR_BANK_MASK |=> bank_mask == $past(cmd.ca_f[9:2]);
  endproperty
  a_mrw_bank: assert property (p_mrw_bank) else $error("bank mask not written"); // R9
  property p_tsi;
    tsi_cnt < 20'(TSI_CYCLES);
  endproperty
  a_tsi: assert property (p_tsi) else $error("sensor interval overrun"); // R23

  c_mrr: cover property (accept_mrr ##A_RL !dq_bus.dq_oe_n);
  c_sre_exit: cover property ($fell(sr_active) ##3 $fell(xsr_busy));
  c_ref: cover property (ref_strobe);
  c_ref_masked: cover property (ref_tick && bank_mask[ref_ptr[5:3]]);

endmodule // srm_self_refresh
`default_nettype wire

//--- srm_ctrl_model.sv
// controller model: drives cke and the command bus, captures mode register reads
// assumes clk comes from the bench; every change lands 1 ns after a rising edge
`timescale 1ns/1ns
`default_nettype none
module srm_ctrl_model
  import srm_pkg::*;
(
  input wire logic clk,       // command clock
  input wire srm_dq_t dq_bus, // data and strobes from the device
  output logic cke,           // clock enable
  output srm_cmd_t cmd        // chip select and command/address
);
  localparam srm_cmd_t NOP = '{1'b1, 10'h000, 10'h000};

  initial begin
    cke = 1'b0;
    cmd = NOP;
  end

  // ----------------------------------------
  // command primitives
  // ----------------------------------------
  // deselected ca lines never repeat, so a stale value cannot pass for a command
  task automatic step(input logic k, input srm_cmd_t c);
    @(posedge clk);
    #1;
    if (c.cs_n) begin
      c.ca_r = ~cmd.ca_r;
      c.ca_f = ~cmd.ca_f;
    end
    cke = k;
    cmd = c;
  endtask

  // clock already running before cke rises
  task automatic wake();
    repeat (2) step(1'b1, NOP);
  endtask

  task automatic nop(input int n);
    repeat (n) step(1'b1, NOP);
  endtask

  task automatic mrw(input logic [7:0] addr, input logic [7:0] data);
    step(1'b1, '{1'b0, {addr[7:2], CA_OP_MRW}, {data, addr[1:0]}});
    step(1'b1, NOP);
  endtask

  // returns beat-0 byte, strobes of four beats, output enable after edges 3..7
  task automatic mrr(input logic [7:0] addr, input logic intrude, input logic [7:0] stray,
                     output logic [7:0] data, output logic [15:0] dqs_seq, output logic [4:0] oe_seq);
    step(1'b1, '{1'b0, {addr[7:2], CA_OP_MRR}, {8'h00, addr[1:0]}});
    for (int i = 0; i < 8; i++) begin
      if (intrude && i == 1)
        step(1'b1, '{1'b0, {MR_ADDR_BANK_MASK[7:2], CA_OP_MRW}, {stray, MR_ADDR_BANK_MASK[1:0]}});
      else
        step(1'b1, NOP);
      if (i == 3)
        data = dq_bus.dq[7:0];
      if (i >= 3 && i <= 6)
        dqs_seq[15 - 4 * (i - 3) -: 4] = dq_bus.dqs;
      if (i >= 3)
        oe_seq[7 - i] = dq_bus.dq_oe_n;
    end
    // returns after edge 7: later commands already meet the read/write spacing
  endtask

  // banks are never opened by this model, so entry is always from idle
  task automatic sre();
    step(1'b0, '{1'b0, 10'h004, 10'h000});
    step(1'b0, NOP);
  endtask

  // inputs other than cke are free while in self refresh
  task automatic hold(input int n);
    repeat (n) step(1'b0, srm_cmd_t'(~cmd));
  endtask

  task automatic srx();
    step(1'b1, NOP);
  endtask
endmodule // srm_ctrl_model
`default_nettype wire

//--- tb_srm_self_refresh.sv
// testbench for the self refresh / mode register read block
// assumes the controller model beside it; sensor update interval shortened to 50 clocks
`timescale 1ns/1ns
`default_nettype none
module tb_srm_self_refresh;
  import srm_pkg::*;
  localparam int TSI = 50;
  localparam int LIMIT = 12000;
  logic clk;
  logic rst_n;
  logic [2:0] temp_sensor;
  srm_cmd_t cmd;
  logic cke;
  srm_dq_t dq_bus;
  logic sr_active, xsr_busy, ref_strobe, ref_all;
  logic [2:0] ref_bank, ref_segment;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int strobes = 0;
  logic [7:0] exp_bank = 8'h00;
  logic [7:0] exp_seg = 8'h00;

  srm_self_refresh #(.TSI_CYCLES(TSI)) i_srm_self_refresh (
    .clk(clk), .rst_n(rst_n), .cke(cke), .cmd(cmd), .temp_sensor(temp_sensor),
    .dq_bus(dq_bus), .sr_active(sr_active), .xsr_busy(xsr_busy), .ref_strobe(ref_strobe),
    .ref_all(ref_all), .ref_bank(ref_bank), .ref_segment(ref_segment));
  srm_ctrl_model i_srm_ctrl_model (.clk(clk), .dq_bus(dq_bus), .cke(cke), .cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard, far above the longest self refresh stay
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  // every internal segment refresh must fall on an unmasked bank and segment
  always @(posedge clk) begin
    #2;
    if (ref_strobe === 1'b1) begin
      strobes++;
      check_bit(exp_bank[ref_bank] | exp_seg[ref_segment], 1'b0, "masked refresh");
    end
  end

  // one read with its strobes and output enable judged as well
  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp, input logic intrude);
    logic [7:0] data;
    logic [15:0] dqs_seq;
    logic [4:0] oe_seq;
    i_srm_ctrl_model.mrr(addr, intrude, 8'hA5, data, dqs_seq, oe_seq);
    check_val({8'h00, data}, {8'h00, exp}, "read byte");
    check_val(dqs_seq, 16'hF0F0, "read strobes");
    check_val({11'h000, oe_seq}, 16'h0001, "read enable");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset_values();
    read_check(MR_ADDR_BANK_MASK, BANK_MASK_RESET, 1'b0);
    read_check(MR_ADDR_SEG_MASK, SEG_MASK_RESET, 1'b0);
    read_check(MR_ADDR_TEMP, 8'h03, 1'b0);
    $display("test reset values done");
  endtask

  task automatic test_mask_access();
    exp_bank = 8'h82;
    exp_seg = 8'h84;
    i_srm_ctrl_model.mrw(MR_ADDR_BANK_MASK, exp_bank);
    i_srm_ctrl_model.mrw(MR_ADDR_SEG_MASK, exp_seg);
    i_srm_ctrl_model.mrw(MR_ADDR_TEMP, 8'h00);
    i_srm_ctrl_model.mrw(8'h20, 8'hFF);
    read_check(MR_ADDR_BANK_MASK, 8'h82, 1'b0);
    read_check(MR_ADDR_SEG_MASK, 8'h84, 1'b0);
    read_check(8'h20, 8'h00, 1'b0);
    temp_sensor = 3'h6;
    i_srm_ctrl_model.nop(TSI + 10);
    read_check(MR_ADDR_TEMP, 8'h06, 1'b0);
    $display("test mask access done");
  endtask

  // a write slipped inside the read window must be dropped
  task automatic test_read_window();
    read_check(MR_ADDR_BANK_MASK, 8'h82, 1'b1);
    read_check(MR_ADDR_BANK_MASK, 8'h82, 1'b0);
    $display("test read window done");
  endtask

  task automatic test_self_refresh();
    int expect_cnt;
    expect_cnt = 0;
    for (int b = 0; b <= int'(BANK_LAST); b++)
      for (int s = 0; s < 8; s++)
        if (!exp_bank[b] && !exp_seg[s])
          expect_cnt++;
    i_srm_ctrl_model.sre();
    check_bit(sr_active, 1'b1, "entry");
    check_bit(ref_all, 1'b1, "entry refresh");
    i_srm_ctrl_model.hold(1);
    check_bit(ref_all, 1'b0, "entry refresh pulse");
    strobes = 0;
    // one full sweep of 64 ticks of 97 clocks, ending well before the next tick
    i_srm_ctrl_model.hold(64 * 97 + 30);
    check_val(strobes[15:0], expect_cnt[15:0], "refresh count");
    temp_sensor = 3'h5;
    i_srm_ctrl_model.hold(8);
    check_bit(sr_active, 1'b1, "still in self refresh");
    i_srm_ctrl_model.srx();
    for (int i = 0; i < 4; i++) begin
      i_srm_ctrl_model.nop(1);
      check_bit(sr_active, 1'b0, "exit");
      check_bit(xsr_busy, i < 3, "exit interval");
    end
    read_check(MR_ADDR_TEMP, 8'h05, 1'b0);
    read_check(MR_ADDR_SEG_MASK, 8'h84, 1'b0);
    $display("test self refresh done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    temp_sensor = 3'h3;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    i_srm_ctrl_model.wake();
    test_reset_values();
    test_mask_access();
    test_read_window();
    test_self_refresh();
    print_verdict();
  end
endmodule // tb_srm_self_refresh
`default_nettype wire
